// ==== include/tocu_pkg.sv ====
// package for the timer16 output compare units: offsets, fields, resets, types
`default_nettype none
package tocu_pkg;
   // register offsets on the byte-wide register port
   localparam logic [3:0] OFF_COMPARE_VALUE_HIGH_A = 4'h0;
   localparam logic [3:0] OFF_COMPARE_VALUE_LOW_A = 4'h1;
   localparam logic [3:0] OFF_COMPARE_VALUE_HIGH_B = 4'h2;
   localparam logic [3:0] OFF_COMPARE_VALUE_LOW_B = 4'h3;
   localparam logic [3:0] OFF_ACTION_CTRL = 4'h4;
   localparam logic [3:0] OFF_MODE_CTRL = 4'h5;
   localparam logic [3:0] OFF_IRQ_ENABLE = 4'h6;
   localparam logic [3:0] OFF_MATCH_STATUS = 4'h7;
   // field positions
   localparam int ACT_A_LSB = 6;
   localparam int ACT_B_LSB = 4;
   localparam int FORCE_A_BIT = 3;
   localparam int FORCE_B_BIT = 2;
   localparam int MODE_LSB = 0;
   localparam int EN_A_BIT = 0;
   localparam int EN_B_BIT = 1;
   localparam int FLAG_A_BIT = 0;
   localparam int FLAG_B_BIT = 1;
   localparam int STATE_A_BIT = 2;
   localparam int STATE_B_BIT = 3;
   // reset values
   localparam logic [15:0] RST_COMPARE = 16'h0000;
   localparam logic [3:0] RST_MODE = 4'h0;
   localparam logic [1:0] RST_ACTION = 2'h0;
   localparam logic RST_STATE = 1'b0;
   localparam logic [1:0] RST_IRQ_EN = 2'h0;
   // waveform mode values and mode classes (bit n set = mode n in class)
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_A = 4'h4;
   localparam logic [3:0] MODE_CTC_CAPTURE = 4'hc;
   localparam logic [15:0] PWM_MODES = 16'hcfee;
   localparam logic [15:0] BOTTOM_UPDATE_MODES = 16'h0300;
   localparam logic [15:0] FAST_MODES = 16'hc0e0;
   // output action select codes
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   // timer-side signals from the counter
   typedef struct packed {
      logic tick;          // timer clock enable
      logic top;           // counter at top
      logic bottom;        // counter at zero
      logic down;          // counting downward
      logic cnt_wr;        // cpu write to the counter
      logic [15:0] value;  // counter value
   } tocu_timer_t;
   // main module state
   typedef struct packed {
      logic [7:0] temp;
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic [3:0] mode;
      logic [1:0] irq_en;
      logic block;
      logic [7:0] rdata;
   } tocu_top_st_t;
   // channel state
   typedef struct packed {
      logic [15:0] buffer;
      logic [15:0] active;
      logic flag;
   } tocu_chan_st_t;
endpackage
`default_nettype wire

// ==== hw/tocu_channel.sv ====
// one compare channel: comparator, double buffer and match flag
`default_nettype none
module tocu_channel (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire tocu_pkg::tocu_timer_t tmr,
   input wire logic load,
   input wire logic [15:0] load_value,
   input wire logic buffered,
   input wire logic update_now,
   input wire logic match_allow,
   input wire logic flag_clear,
   output logic [15:0] compare_value,
   output logic [15:0] cpu_view,
   output logic match_hit,
   output logic match_flag
);
   import tocu_pkg::*;
   tocu_chan_st_t s;       // registered state
   tocu_chan_st_t next_s;  // next state
   // equality compare on every cycle, qualified at the timer tick
   assign match_hit = (tmr.value == s.active) && match_allow; // [RULE1] [RULE2]
   assign compare_value = s.active;
   // cpu sees buffer when buffered, active otherwise, no byte latch
   assign cpu_view = buffered ? s.buffer : s.active; // [RULE9] [RULE10]
   assign match_flag = s.flag;
   // next state
   always_comb begin
      next_s = s;
      // transfer at top or bottom only when buffered
      if (buffered && update_now) begin
         next_s.active = s.buffer; // [RULE8]
      end
      // only cpu writes change the value
      if (load) begin
         next_s.buffer = load_value; // [RULE10]
         if (!buffered) begin
            next_s.active = load_value; // [RULE7]
         end
      end
      // set wins over clear
      if (match_hit) begin
         next_s.flag = 1'b1; // [RULE2]
      end else if (flag_clear) begin
         next_s.flag = 1'b0; // [RULE3] [RULE4]
      end
   end
   // state register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{buffer: RST_COMPARE, active: RST_COMPARE, flag: 1'b0};
      end else begin
         s <= next_s;
      end
   end
   property p_flag_set;
      @(posedge mclk) disable iff (sys_rst) match_hit |=> match_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) // [RULE2]
      else $error("flag not set after match");
   property p_buffer_hold;
      @(posedge mclk) disable iff (sys_rst)
         buffered && !update_now |=> compare_value == $past(compare_value);
   endproperty
   a_buffer_hold: assert property (p_buffer_hold) // [RULE8]
      else $error("buffered compare changed off top or bottom");
   property p_direct_load;
      @(posedge mclk) disable iff (sys_rst)
         load && !buffered |=> compare_value == $past(load_value);
   endproperty
   a_direct_load: assert property (p_direct_load) // [RULE7]
      else $error("unbuffered write not applied");
   c_buffer_update: cover property (@(posedge mclk) buffered && update_now && load);
endmodule // tocu_channel
`default_nettype wire

// ==== hw/tocu_outunit.sv ====
// output action unit: output state register and port override
`default_nettype none
module tocu_outunit (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire tocu_pkg::tocu_timer_t tmr,
   input wire logic match_hit,
   input wire logic force_match_strobe,
   input wire logic [1:0] output_action_sel,
   input wire logic [1:0] force_action,
   input wire logic pwm,
   input wire logic fast,
   input wire logic port_value,
   input wire logic output_pin_direction_bit,
   output logic compare_output_state,
   output logic pin_out,
   output logic pin_oe
);
   import tocu_pkg::*;
   logic s;       // internal output state, not the pin
   logic next_s;  // next state
   // action from match, force or bottom of a fast cycle
   always_comb begin
      next_s = s;
      if (!pwm) begin
         // non-pwm: set, clear, toggle; force acts as a match
         if (force_match_strobe || match_hit) begin
            case (force_match_strobe ? force_action : output_action_sel) // [RULE12] [RULE15]
               ACT_TOGGLE: next_s = ~s; // [RULE22] [RULE25]
               ACT_CLEAR: next_s = 1'b0; // [RULE25]
               ACT_SET: next_s = 1'b1; // [RULE25]
               default: next_s = s; // [RULE19]
            endcase
         end
      end else if (output_action_sel[1]) begin
         // pwm: code 3 inverts, codes 0 and 1 take no action
         if (match_hit) begin
            next_s = fast ? output_action_sel[0] : (output_action_sel[0] ^ tmr.down); // [RULE5]
         end else if (fast && tmr.tick && tmr.bottom) begin
            next_s = ~output_action_sel[0]; // [RULE5]
         end
      end
   end
   // output state register, cleared by system reset
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= RST_STATE; // [RULE16]
      end else begin
         s <= next_s;
      end
   end
   assign compare_output_state = s;
   // any nonzero action overrides the port value, direction stays with port
   assign pin_out = (output_action_sel != ACT_NONE) ? s : port_value; // [RULE17] [RULE21]
   assign pin_oe = output_pin_direction_bit; // [RULE18]
   property p_no_action;
      @(posedge mclk) disable iff (sys_rst)
         output_action_sel == ACT_NONE && !force_match_strobe |=> $stable(s);
   endproperty
   a_no_action: assert property (p_no_action) // [RULE19]
      else $error("output changed with action zero");
   property p_toggle;
      @(posedge mclk) disable iff (sys_rst)
         !pwm && !force_match_strobe && match_hit && output_action_sel == ACT_TOGGLE
         |=> s != $past(s);
   endproperty
   a_toggle: assert property (p_toggle) // [RULE25]
      else $error("toggle action did not toggle");
   property p_override;
      @(posedge mclk) disable iff (sys_rst)
         output_action_sel != ACT_NONE |-> pin_out == s;
   endproperty
   a_override: assert property (p_override) // [RULE17]
      else $error("pin not overridden by output state");
   c_force: cover property (@(posedge mclk) force_match_strobe && !pwm);
endmodule // tocu_outunit
`default_nettype wire

// ==== hw/tocu_top.sv ====
// timer16 output compare units: register port, shared byte latch, two channels
//
// Notes on behaviour
// RULE1 - compare counter and compare value every cycle
// RULE2 - match flag sets at next timer tick
// RULE3 - enabled flag requests irq, ack clears it
// RULE4 - writing one clears flag, zero ignored
// RULE5 - output from match, mode, action, top/bottom
// RULE6 - channel a value serves as counter top
// RULE7 - buffered in pwm modes, direct otherwise
// RULE8 - buffer moves to active at top/bottom
// RULE9 - cpu reaches buffer or active per mode
// RULE10 - only cpu writes change it; direct reads
// RULE11 - high byte latched, low write loads sixteen
// RULE12 - force acts like match, no flag
// RULE13 - counter write blocks matches next tick
// RULE14 - counter written to top misses top match
// RULE15 - action select unbuffered, next match applies
// RULE16 - output state cleared by system reset
// RULE17 - nonzero action overrides port output value
// RULE18 - software sets pin direction as output
// RULE19 - action zero leaves output state alone
// RULE20 - action select never touches input capture
// RULE21 - output state settable before override shows
// RULE22 - non-pwm actions set, clear or toggle
// RULE23 - modes 4 and 12 clear on match; ctc_clear_req is raised in mode 4 only
// RULE24 - mode 0 counts up freely, wraps
// RULE25 - codes 01 toggle, 10 clear, 11 set
`default_nettype none
module tocu_top (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [3:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire tocu_pkg::tocu_timer_t tmr,
   input wire logic irq_ack_a,
   input wire logic irq_ack_b,
   output logic irq_a,
   output logic irq_b,
   input wire logic port_value_a,
   input wire logic port_value_b,
   input wire logic output_pin_direction_bit_a,
   input wire logic output_pin_direction_bit_b,
   output logic pin_out_a,
   output logic pin_oe_a,
   output logic pin_out_b,
   output logic pin_oe_b,
   output logic [15:0] channel_a_compare_reg,
   output logic top_match_a,
   output logic ctc_clear_req
);
   import tocu_pkg::*;

   tocu_top_st_t s;          // registered state
   tocu_top_st_t next_s;     // next state

   logic pwm;                // one of the twelve pwm modes
   logic fast;               // single-slope pwm
   logic update_now;         // buffer transfer point
   logic match_allow;        // timer tick with no block
   logic load_a;             // low byte write, channel a
   logic load_b;             // low byte write, channel b
   logic [15:0] load_value;  // latched high byte plus low byte
   logic clear_a;            // flag clear, channel a
   logic clear_b;            // flag clear, channel b
   logic force_a;            // force strobe, channel a
   logic force_b;            // force strobe, channel b
   logic [1:0] new_act_a;    // action being written, channel a
   logic [1:0] new_act_b;    // action being written, channel b
   logic [15:0] view_a;      // cpu view, channel a
   logic [15:0] view_b;      // cpu view, channel b
   logic hit_a;              // qualified match, channel a
   logic hit_b;              // qualified match, channel b
   logic flag_a;             // compare_match_flag a
   logic flag_b;             // compare_match_flag b
   logic state_a;            // compare_output_state a
   logic state_b;            // compare_output_state b

   // mode classes from the waveform mode
   assign pwm = PWM_MODES[s.mode]; // [RULE7]
   assign fast = FAST_MODES[s.mode];

   // buffered value moves at top, or at bottom in the bottom-update modes
   assign update_now = tmr.tick &&
      (BOTTOM_UPDATE_MODES[s.mode] ? tmr.bottom : tmr.top); // [RULE8]

   // a counter write blocks every match at the next tick, even if stopped
   assign match_allow = tmr.tick && !s.block; // [RULE13]

   // sixteen-bit load from latch and low byte in one cycle
   assign load_value = {s.temp, bus_wdata}; // [RULE11]
   assign load_a = bus_wr && (bus_addr == OFF_COMPARE_VALUE_LOW_A); // [RULE11]
   assign load_b = bus_wr && (bus_addr == OFF_COMPARE_VALUE_LOW_B); // [RULE11]

   // write-one-to-clear or interrupt service clears the flag
   assign clear_a = (bus_wr && (bus_addr == OFF_MATCH_STATUS) && bus_wdata[FLAG_A_BIT])
      || irq_ack_a; // [RULE3] [RULE4]
   assign clear_b = (bus_wr && (bus_addr == OFF_MATCH_STATUS) && bus_wdata[FLAG_B_BIT])
      || irq_ack_b; // [RULE3] [RULE4]

   // force strobes only act in non-pwm modes; they are never stored
   assign force_a = bus_wr && (bus_addr == OFF_ACTION_CTRL)
      && bus_wdata[FORCE_A_BIT] && !pwm; // [RULE12]
   assign force_b = bus_wr && (bus_addr == OFF_ACTION_CTRL)
      && bus_wdata[FORCE_B_BIT] && !pwm; // [RULE12]

   // a force uses the action written beside it
   assign new_act_a = bus_wdata[ACT_A_LSB +: 2];
   assign new_act_b = bus_wdata[ACT_B_LSB +: 2];

   // next state: register writes, byte latch, block, read data
   always_comb begin
      next_s = s;
      next_s.rdata = '0;
      // write decode
      if (bus_wr) begin
         if (bus_addr == OFF_COMPARE_VALUE_HIGH_A) begin
            // shared latch, loaded by either high byte
            next_s.temp = bus_wdata; // [RULE11]
         end else if (bus_addr == OFF_COMPARE_VALUE_HIGH_B) begin
            next_s.temp = bus_wdata; // [RULE11]
         end else if (bus_addr == OFF_ACTION_CTRL) begin
            // takes effect at the next match, no buffering
            next_s.act_a = new_act_a; // [RULE15]
            next_s.act_b = new_act_b; // [RULE15]
         end else if (bus_addr == OFF_MODE_CTRL) begin
            next_s.mode = bus_wdata[MODE_LSB +: 4];
         end else if (bus_addr == OFF_IRQ_ENABLE) begin
            next_s.irq_en = {bus_wdata[EN_B_BIT], bus_wdata[EN_A_BIT]};
         end
      end
      // read decode; compare bytes come straight from the channel
      if (bus_rd) begin
         if (bus_addr == OFF_COMPARE_VALUE_HIGH_A) begin
            next_s.rdata = view_a[15:8]; // [RULE10]
         end else if (bus_addr == OFF_COMPARE_VALUE_LOW_A) begin
            next_s.rdata = view_a[7:0]; // [RULE10]
         end else if (bus_addr == OFF_COMPARE_VALUE_HIGH_B) begin
            next_s.rdata = view_b[15:8]; // [RULE10]
         end else if (bus_addr == OFF_COMPARE_VALUE_LOW_B) begin
            next_s.rdata = view_b[7:0]; // [RULE10]
         end else if (bus_addr == OFF_ACTION_CTRL) begin
            // force bits always read zero
            next_s.rdata[ACT_A_LSB +: 2] = s.act_a;
            next_s.rdata[ACT_B_LSB +: 2] = s.act_b;
         end else if (bus_addr == OFF_MODE_CTRL) begin
            next_s.rdata[MODE_LSB +: 4] = s.mode;
         end else if (bus_addr == OFF_IRQ_ENABLE) begin
            next_s.rdata[EN_A_BIT] = s.irq_en[0];
            next_s.rdata[EN_B_BIT] = s.irq_en[1];
         end else if (bus_addr == OFF_MATCH_STATUS) begin
            next_s.rdata[FLAG_A_BIT] = flag_a;
            next_s.rdata[FLAG_B_BIT] = flag_b;
            next_s.rdata[STATE_A_BIT] = state_a;
            next_s.rdata[STATE_B_BIT] = state_b;
         end
         // unmapped addresses read zero
      end
      // block holds from a counter write until the next tick
      next_s.block = tmr.cnt_wr || (s.block && !tmr.tick); // [RULE13]
   end

   // state register
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s <= '{temp: 8'h00, act_a: RST_ACTION, act_b: RST_ACTION,
                mode: RST_MODE, irq_en: RST_IRQ_EN, block: 1'b0, rdata: 8'h00};
      end else begin
         s <= next_s;
      end
   end

   // read data stands only in the cycle after the read strobe
   assign bus_rdata = s.rdata;

   // interrupt request while flag set and enabled
   assign irq_a = flag_a && s.irq_en[0]; // [RULE3]
   assign irq_b = flag_b && s.irq_en[1]; // [RULE3]

   // channel a
   tocu_channel u_chan_a (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tmr(tmr),
      .load(load_a),
      .load_value(load_value),
      .buffered(pwm),
      .update_now(update_now),
      .match_allow(match_allow),
      .flag_clear(clear_a),
      .compare_value(channel_a_compare_reg),
      .cpu_view(view_a),
      .match_hit(hit_a),
      .match_flag(flag_a)
   );

   // channel b
   tocu_channel u_chan_b (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tmr(tmr),
      .load(load_b),
      .load_value(load_value),
      .buffered(pwm),
      .update_now(update_now),
      .match_allow(match_allow),
      .flag_clear(clear_b),
      .compare_value(),
      .cpu_view(view_b),
      .match_hit(hit_b),
      .match_flag(flag_b)
   );

   // output unit a
   tocu_outunit u_out_a (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tmr(tmr),
      .match_hit(hit_a),
      .force_match_strobe(force_a),
      .output_action_sel(s.act_a),
      .force_action(new_act_a),
      .pwm(pwm),
      .fast(fast),
      .port_value(port_value_a),
      .output_pin_direction_bit(output_pin_direction_bit_a),
      .compare_output_state(state_a),
      .pin_out(pin_out_a),
      .pin_oe(pin_oe_a)
   );

   // output unit b
   tocu_outunit u_out_b (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tmr(tmr),
      .match_hit(hit_b),
      .force_match_strobe(force_b),
      .output_action_sel(s.act_b),
      .force_action(new_act_b),
      .pwm(pwm),
      .fast(fast),
      .port_value(port_value_b),
      .output_pin_direction_bit(output_pin_direction_bit_b),
      .compare_output_state(state_b),
      .pin_out(pin_out_b),
      .pin_oe(pin_oe_b)
   );

   // channel a match is the top hit; a blocked top is simply missed
   assign top_match_a = hit_a; // [RULE6] [RULE14]
   // clear the counter on channel a match in mode 4 only; mode 12 and
   // mode 0 never clear from here, capture lies outside this block
   assign ctc_clear_req = hit_a && (s.mode == MODE_CTC_A); // [RULE23] [RULE24]
   // the action bits reach nothing but the output units and the read data [RULE20]

   property p_block;
      @(posedge mclk) disable iff (sys_rst)
         $past(tmr.cnt_wr) && tmr.tick |-> !hit_a && !hit_b;
   endproperty
   a_block: assert property (p_block) // [RULE13]
      else $error("match not blocked after counter write");

   property p_irq;
      @(posedge mclk) disable iff (sys_rst)
         flag_a && s.irq_en[0] |-> irq_a;
   endproperty
   a_irq: assert property (p_irq) // [RULE3]
      else $error("enabled flag without interrupt request");

   property p_w1c;
      @(posedge mclk) disable iff (sys_rst)
         bus_wr && bus_addr == OFF_MATCH_STATUS && bus_wdata[FLAG_A_BIT] && !hit_a
         |=> !flag_a;
   endproperty
   a_w1c: assert property (p_w1c) // [RULE4]
      else $error("write one did not clear flag");

   property p_force_no_flag;
      @(posedge mclk) disable iff (sys_rst)
         force_a && !hit_a && !flag_a |=> !flag_a;
   endproperty
   a_force_no_flag: assert property (p_force_no_flag) // [RULE12]
      else $error("force set the match flag");

   property p_load16;
      @(posedge mclk) disable iff (sys_rst)
         bus_wr && bus_addr == OFF_COMPARE_VALUE_HIGH_A ##1 !bus_wr ##1 load_a && !pwm
         |=> channel_a_compare_reg == {$past(bus_wdata, 3), $past(bus_wdata)};
   endproperty
   a_load16: assert property (p_load16) // [RULE11]
      else $error("sixteen-bit compare load wrong");

   property p_rdata_once;
      @(posedge mclk) disable iff (sys_rst)
         !bus_rd |=> bus_rdata == 8'h00;
   endproperty
   a_rdata_once: assert property (p_rdata_once)
      else $error("read data outside its cycle");

   property p_ctc;
      @(posedge mclk) disable iff (sys_rst)
         hit_a && s.mode == MODE_CTC_A |-> ctc_clear_req;
   endproperty
   a_ctc: assert property (p_ctc) // [RULE23]
      else $error("no counter clear on mode 4 match");

   property p_ack_clear;
      @(posedge mclk) disable iff (sys_rst)
         irq_ack_a && !hit_a |=> !flag_a;
   endproperty
   a_ack_clear: assert property (p_ack_clear) // [RULE3]
      else $error("serviced interrupt left flag set");

   property p_flag_hold;
      @(posedge mclk) disable iff (sys_rst)
         flag_a && !clear_a |=> flag_a;
   endproperty
   a_flag_hold: assert property (p_flag_hold) // [RULE4]
      else $error("flag dropped without a clear");

   property p_w1c_b;
      @(posedge mclk) disable iff (sys_rst)
         bus_wr && bus_addr == OFF_MATCH_STATUS && bus_wdata[FLAG_B_BIT] && !hit_b
         |=> !flag_b;
   endproperty
   a_w1c_b: assert property (p_w1c_b) // [RULE4]
      else $error("write one did not clear flag b");

   property p_top_hit;
      @(posedge mclk) disable iff (sys_rst)
         tmr.tick && !s.block && tmr.value == channel_a_compare_reg |-> top_match_a;
   endproperty
   a_top_hit: assert property (p_top_hit) // [RULE1] [RULE6]
      else $error("equal counter and compare gave no top match");

   property p_blocked_any;
      @(posedge mclk) disable iff (sys_rst)
         s.block && tmr.tick |-> !hit_a && !hit_b;
   endproperty
   a_blocked_any: assert property (p_blocked_any) // [RULE13] [RULE14]
      else $error("match taken while blocked");

   c_match_a: cover property (@(posedge mclk) hit_a && s.irq_en[0]);
   c_blocked: cover property (@(posedge mclk) s.block && tmr.tick);
endmodule // tocu_top
`default_nettype wire

// ==== sim/tb_tocu_top.sv ====
// self-checking bench for the timer16 output compare units
`default_nettype none
module tb_tocu_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tocu_pkg::*;
   logic mclk, sys_rst, bus_wr, bus_rd, irq_ack_a, irq_ack_b, irq_a, irq_b;
   logic pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, top_match_a, ctc_clear_req;
   logic [3:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, d;
   logic [15:0] channel_a_compare_reg, c, b;
   logic [15:0] cv [2];  // compare values written per channel
   logic [1:0] act [2];  // action code per channel
   logic [1:0] pv, dir, fl, st, tm, iq;  // pins, expected flags and states, tick samples
   tocu_timer_t tmr;  // counter side, driven here
   int n_fail = 0;
   int samples_checked = 0;
   tocu_top dut (.mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .tmr(tmr),
      .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b), .irq_a(irq_a), .irq_b(irq_b),
      .port_value_a(pv[0]), .port_value_b(pv[1]), .output_pin_direction_bit_a(dir[0]),
      .output_pin_direction_bit_b(dir[1]), .pin_out_a(pin_out_a), .pin_oe_a(pin_oe_a),
      .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b),
      .channel_a_compare_reg(channel_a_compare_reg), .top_match_a(top_match_a),
      .ctc_clear_req(ctc_clear_req));
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle register write, then an idle cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
      @(posedge mclk);
   endtask
   // one-cycle read, data taken in the following cycle only
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1;
      v = bus_rdata;
      @(posedge mclk);
   endtask
   // one timer tick at counter value v, sampling the tick cycle
   task automatic tk(input logic [15:0] v, input logic t);
      tmr.value <= v;
      tmr.top <= t;
      tmr.tick <= 1'b1;
      #1;
      tm = {ctc_clear_req, top_match_a};
      iq = {irq_b, irq_a};
      @(posedge mclk);
      tmr.tick <= 1'b0;
      tmr.top <= 1'b0;
      @(posedge mclk);
   endtask
   // expected output state after a match
   function automatic logic nx(input logic [1:0] code, input logic s);
      case (code)
         ACT_TOGGLE: return ~s;
         ACT_CLEAR: return 1'b0;
         ACT_SET: return 1'b1;
         default: return s;
      endcase
   endfunction
   // write both action fields plus force bits
   task automatic setact(input logic [1:0] f);
      wr(OFF_ACTION_CTRL, {act[0], act[1], f, 2'b00});
   endtask
   // status byte and pin checks
   task automatic stat();
      rd(OFF_MATCH_STATUS, d);
      chk(16'(d), 16'({st, fl}));
      chk(16'({pin_out_b, pin_out_a}), 16'({act[1] != 0 ? st[1] : pv[1],
         act[0] != 0 ? st[0] : pv[0]}));
      chk(16'({pin_oe_b, pin_oe_a}), 16'(dir));
   endtask
   // verdict and end of run
   task automatic end_of_test();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // watchdog against hangs
   initial begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
   // main sequence
   initial begin
      void'($urandom(32'h5c7d_9192));
      sys_rst = 1'b1;
      {bus_wr, bus_rd, irq_ack_a, irq_ack_b, fl, st, bus_addr, bus_wdata} = '0;
      act = '{default: 2'h0};
      tmr = '0;
      pv = 2'($urandom);
      dir = 2'($urandom);
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      stat();
      for (int ch = 0; ch < 2; ch++) begin
         c = 16'($urandom);
         cv[ch] = c;
         wr(4'(2 * ch), c[15:8]);
         wr(4'(2 * ch + 1), c[7:0]);
         rd(4'(2 * ch), d);
         chk(16'(d), 16'(c[15:8]));
         rd(4'(2 * ch + 1), d);
         chk(16'(d), 16'(c[7:0]));
         if (ch == 0) chk(channel_a_compare_reg, c);
         tk(c ^ 16'h8001, 1'b0);
         stat();
         wr(OFF_IRQ_ENABLE, 8'h03);
         for (int code = 0; code < 4; code++) begin
            act[ch] = 2'(code);
            setact(2'h0);
            pv <= 2'($urandom);
            dir <= 2'($urandom);
            tk(c, 1'b0);
            chk(16'(iq[ch]), 16'h0000);
            if (ch == 0) chk(16'(tm[0]), 16'h0001);
            fl[ch] = 1'b1;
            st[ch] = nx(act[ch], st[ch]);
            chk(16'({irq_b, irq_a}), 16'(fl));
            stat();
            if (code[0]) begin
               wr(OFF_MATCH_STATUS, 8'h00);
               stat();
               wr(OFF_MATCH_STATUS, 8'(1 << ch));
            end else begin
               if (ch == 0) irq_ack_a <= 1'b1;
               else irq_ack_b <= 1'b1;
               @(posedge mclk);
               {irq_ack_a, irq_ack_b} <= 2'b00;
               @(posedge mclk);
            end
            fl[ch] = 1'b0;
            stat();
         end
         act[ch] = ACT_TOGGLE;
         setact(2'(2 >> ch));
         st[ch] = ~st[ch];
         stat();
         tmr.cnt_wr <= 1'b1;
         @(posedge mclk);
         tmr.cnt_wr <= 1'b0;
         tk(c, 1'b0);
         stat();
         tk(c, 1'b0);
         st[ch] = ~st[ch];
         fl[ch] = 1'b1;
         stat();
      end
      // pwm mode: writes land in the buffer until top
      wr(OFF_MODE_CTRL, 8'h0e);
      b = 16'($urandom);
      wr(OFF_COMPARE_VALUE_HIGH_A, b[15:8]);
      wr(OFF_COMPARE_VALUE_LOW_A, b[7:0]);
      chk(channel_a_compare_reg, cv[0]);
      rd(OFF_COMPARE_VALUE_LOW_A, d);
      chk(16'(d), 16'(b[7:0]));
      tk(~b, 1'b0);
      chk(channel_a_compare_reg, cv[0]);
      tk(~b, 1'b1);
      chk(channel_a_compare_reg, b);
      wr(OFF_MODE_CTRL, 8'h04);
      tk(b, 1'b0);
      chk(16'(tm), 16'h0003);
      end_of_test();
   end
endmodule  // tb_tocu_top
`default_nettype wire
